// *** verilog/scd_pkg.sv ***
// Purpose: Shared constants and types for the copy engine and millisecond timer
// Assumes: 125 MHz clock, byte-wide special-function register port
// Notes: All offsets, field positions, reset values and timing counts live here
package scd_pkg;
	// Special-function register addresses
	localparam logic [7:0] SFR_INDEX = 8'h9b;
	localparam logic [7:0] SFR_DATA = 8'h9c;
	localparam logic [7:0] SFR_STATUS = 8'h94;
	// Internal register indices
	localparam logic [7:0] IDX_CSR = 8'h00;
	localparam logic [7:0] IDX_SRC = 8'h02;
	localparam logic [7:0] IDX_TGT = 8'h06;
	localparam logic [7:0] IDX_CNT = 8'h0a;
	localparam logic [7:0] IDX_TMR = 8'h0c;
	localparam logic [7:0] IDX_LAST = 8'h0f;
	localparam logic [7:0] IDX_ABORT = 8'hff;
	// Command/status field positions
	localparam int CSR_GO = 0;
	localparam int CSR_FS = 1;
	localparam int CSR_ERR = 2;
	localparam int CSR_SOURCE_IN_RX_RING = 4;
	localparam int CSR_TARGET_IN_TX_RING = 5;
	localparam int CSR_IE = 7;
	// Timer register field positions and reset value
	localparam int TMR_RUN = 12;
	localparam int TMR_CLR = 13;
	localparam int TMR_IE = 15;
	localparam logic [15:0] TMR_RESET = 16'h0001;
	localparam logic [15:0] TMR_WMASK = 16'hf3ff;
	// Status register field positions
	localparam int ST_DONE = 0;
	localparam int ST_TO = 1;
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
	localparam int CHUNK_BYTES = 128;
	localparam int GAP_CYCLES = 16;
	localparam logic [10:0] TMR_MAX = 11'h0400;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b00_0001,
		ST_CHECK = 6'b00_0010,
		ST_RD = 6'b00_0100,
		ST_WR = 6'b00_1000,
		ST_GAP = 6'b01_0000,
		ST_ERR = 6'b10_0000
	} scd_state_t;

	// Memory request bundle toward the arbiter
	typedef struct packed {
		logic req;
		logic we;
		logic [23:0] addr;
		logic [7:0] wdata;
	} scd_mem_t;

	typedef struct packed {
		scd_state_t state;
		logic [7:0] idx;
		logic [31:0] gather;
		logic [1:0] gcnt;
		logic [1:0] rptr;
		logic go;
		logic fs;
		logic err;
		logic source_in_rx_ring;
		logic target_in_tx_ring;
		logic done_ie;
		logic [23:0] src;
		logic [23:0] tgt;
		logic [15:0] cnt;
		logic [23:0] cur_src;
		logic [23:0] cur_tgt;
		logic [15:0] remain;
		logic [7:0] chunk;
		logic [15:0] gap;
		logic [15:0] tmr;
		logic done_flag;
		logic to_flag;
		logic [7:0] rdata;
		logic irq;
		scd_mem_t mem;
	} scd_top_st_t;

	typedef struct packed {
		logic [31:0] pre;
		logic [10:0] cnt;
		logic hit;
	} scd_tmr_st_t;
endpackage

// *** verilog/scd_buf2.sv ***
// Purpose: Two-entry byte buffer between the read and write halves of a copy
// Assumes: Single clock; flush drops any held entries
// Notes: Ready and valid on both sides; full and empty are exact
module scd_buf2 #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic wp;
		logic rp;
		logic [1:0] count;
	} scd_buf_st_t;

	scd_buf_st_t s_q, s_d;
	logic push, pop;

	// Exact full and empty from the occupancy count
	assign in_ready = (s_q.count != 2'd2);
	assign out_valid = (s_q.count != 2'd0);
	assign out_data = s_q.mem[s_q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and occupancy update
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = ~s_q.wp;
		end
		if (pop)
			s_d.rp = ~s_q.rp;
		if (push && !pop)
			s_d.count = s_q.count + 2'd1;
		else if (pop && !push)
			s_d.count = s_q.count - 2'd1;
		if (flush) begin
			s_d.wp = 1'b0;
			s_d.rp = 1'b0;
			s_d.count = 2'd0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule

// *** verilog/scd_ms_timer.sv ***
// Purpose: Millisecond tick counter with programmable wrap point
// Assumes: CYC_PER_MS clock cycles make one millisecond
// Notes: A limit of zero is taken as the maximum span
module scd_ms_timer #(
	parameter int CYC_PER_MS = scd_pkg::MS_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic clear,
	input wire logic [9:0] limit,
	output logic hit
);
	scd_pkg::scd_tmr_st_t s_q, s_d;
	logic [10:0] lim;
	logic [10:0] nxt;

	assign hit = s_q.hit;
	assign lim = (limit == 10'h000) ? scd_pkg::TMR_MAX : {1'b0, limit};
	assign nxt = s_q.cnt + 11'd1;

	// Prescale to one millisecond, then count and wrap at the limit
	always_comb begin
		s_d = s_q;
		s_d.hit = 1'b0;
		if (clear) begin
			s_d.pre = '0;
			s_d.cnt = '0;
		end else if (run) begin
			if (s_q.pre == 32'(CYC_PER_MS - 1)) begin
				s_d.pre = '0;
				if (nxt >= lim) begin
					s_d.cnt = '0;
					s_d.hit = 1'b1;
				end else begin
					s_d.cnt = nxt;
				end
			end else begin
				s_d.pre = s_q.pre + 32'd1;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	a_timer_hold: assert property (@(posedge clk) disable iff (!reset_n)
		(!run && !clear) |=> $stable(s_q.cnt) && !hit)
		else $error("timer moved while stopped");
	a_timer_wrap: assert property (@(posedge clk) disable iff (!reset_n)
		hit |-> s_q.cnt == 11'd0 && $past(run))
		else $error("timer hit without wrap to zero");
endmodule

// *** verilog/scd_top.sv ***
// Purpose: Block copy engine in data memory with a millisecond timer
// Assumes: Byte-wide special-function port; one-request arbiter port
// Notes: Internal registers are reached through index and data registers
// How it works
// - Timeout flag set on wrap, read clears
// - Index write, then data reads LSB first
// - Data bytes gathered, committed by index write
// - Indices 00,02,06,0A,0C select internal registers
// - Run bit starts copy, self-clears, ignores zero
// - Force stop aborts, clears itself and run
// - Error on zero count, equal or overlap
// - Error when ring address lies outside ring
// - Source follows receive ring with wrap
// - Target follows transmit ring with wrap
// - Completion raises shared interrupt when enabled
// - Start addresses held as 24-bit bytes
// - Copy split into chunks of 128 bytes
// - Timer ticks per millisecond, wraps at timeout
// - Timeout raises shared interrupt when enabled
// - Timer counts only while run bit set
// - Timer clear bit zeroes counter, self-clears
// - Index 0x00-0x0f selects, 0xff aborts
// - Done flag set on completion, read clears
// - Non-ring copies step addresses linearly
module scd_top #(
	parameter int CYC_PER_MS = scd_pkg::MS_CYCLES,
	parameter int GAP_CYC = scd_pkg::GAP_CYCLES
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	input wire logic [15:0] rx_ring_start_page,
	input wire logic [15:0] rx_ring_end_page,
	input wire logic [15:0] tx_ring_start_page,
	input wire logic [15:0] tx_ring_end_page,
	output logic mem_req,
	output logic mem_we,
	output logic [23:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	output logic shared_irq_line
);
	scd_pkg::scd_top_st_t s_q, s_d;
	logic tmr_hit;
	logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready, buf_flush;
	logic [7:0] buf_out_data;
	logic [24:0] src_end, tgt_end;
	logic bad_range, bad_ring;
	logic [31:0] rd_view;

	// Every output straight from the state register
	assign sfr_rdata = s_q.rdata;
	assign mem_req = s_q.mem.req;
	assign mem_we = s_q.mem.we;
	assign mem_addr = s_q.mem.addr;
	assign mem_wdata = s_q.mem.wdata;
	assign shared_irq_line = s_q.irq;

	// Read data is parked in the buffer so a slow write grant loses nothing
	assign buf_in_valid = (s_q.state == scd_pkg::ST_RD) && s_q.mem.req && mem_ack;
	assign buf_out_ready = (s_q.state == scd_pkg::ST_WR) && s_q.mem.req && mem_ack;
	assign buf_flush = s_q.fs && !s_q.mem.req;

	scd_buf2 #(
		.W(8)
	) u_buf (
		.clk(clk),
		.reset_n(reset_n),
		.flush(buf_flush),
		.in_valid(buf_in_valid),
		.in_ready(buf_in_ready),
		.in_data(mem_rdata),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_data(buf_out_data)
	);

	scd_ms_timer #(
		.CYC_PER_MS(CYC_PER_MS)
	) u_tmr (
		.clk(clk),
		.reset_n(reset_n),
		.run(s_q.tmr[scd_pkg::TMR_RUN]),
		.clear(s_q.tmr[scd_pkg::TMR_CLR]),
		.limit(s_q.tmr[9:0]),
		.hit(tmr_hit)
	);

	// Range checks done once before the first byte moves
	assign src_end = {1'b0, s_q.src} + {9'h000, s_q.cnt};
	assign tgt_end = {1'b0, s_q.tgt} + {9'h000, s_q.cnt};
	assign bad_range = (s_q.cnt == 16'h0000) || (s_q.tgt == s_q.src)
		|| (({1'b0, s_q.tgt} < src_end) && ({1'b0, s_q.src} < tgt_end));
	assign bad_ring = (s_q.source_in_rx_ring && ((s_q.src[23:8] < rx_ring_start_page)
		|| (s_q.src[23:8] > rx_ring_end_page)))
		|| (s_q.target_in_tx_ring && ((s_q.tgt[23:8] < tx_ring_start_page)
		|| (s_q.tgt[23:8] > tx_ring_end_page)));

	// Byte view of the register chosen by the index, for LSB-first reads
	always_comb begin
		rd_view = 32'h0000_0000;
		case (s_q.idx)
			scd_pkg::IDX_CSR: rd_view = {24'h00_0000, s_q.done_ie, 1'b0, s_q.target_in_tx_ring, s_q.source_in_rx_ring,
				1'b0, s_q.err, s_q.fs, s_q.go};
			scd_pkg::IDX_SRC: rd_view = {8'h00, s_q.src};
			scd_pkg::IDX_TGT: rd_view = {8'h00, s_q.tgt};
			scd_pkg::IDX_CNT: rd_view = {16'h0000, s_q.cnt};
			scd_pkg::IDX_TMR: rd_view = {16'h0000, s_q.tmr};
			default: rd_view = 32'h0000_0000;
		endcase
	end

	// Next address: linear, or wrap to the first ring page past the last one
	function automatic logic [23:0] step(input logic [23:0] a, input logic ring,
		input logic [15:0] sp, input logic [15:0] ep);
		if (ring && (a[7:0] == 8'hff) && (a[23:8] == ep))
			step = {sp, 8'h00};
		else
			step = a + 24'h00_0001;
	endfunction

	// Engine, register access and flags in one next-state process
	always_comb begin
		s_d = s_q;
		s_d.tmr[scd_pkg::TMR_CLR] = 1'b0;
		case (s_q.state)
			scd_pkg::ST_CHECK: begin
				if (bad_range || bad_ring) begin
					s_d.err = 1'b1;
					s_d.state = scd_pkg::ST_ERR;
				end else begin
					s_d.cur_src = s_q.src;
					s_d.cur_tgt = s_q.tgt;
					s_d.remain = s_q.cnt;
					s_d.chunk = 8'h00;
					s_d.state = scd_pkg::ST_RD;
				end
			end
			scd_pkg::ST_RD: begin
				if (!s_q.mem.req && buf_in_ready && !s_q.fs) begin
					s_d.mem.req = 1'b1;
					s_d.mem.we = 1'b0;
					s_d.mem.addr = s_q.cur_src;
				end else if (s_q.mem.req && mem_ack) begin
					s_d.mem.req = 1'b0;
					s_d.cur_src = step(s_q.cur_src, s_q.source_in_rx_ring, rx_ring_start_page,
						rx_ring_end_page);
					s_d.state = scd_pkg::ST_WR;
				end
			end
			scd_pkg::ST_WR: begin
				if (!s_q.mem.req && buf_out_valid && !s_q.fs) begin
					s_d.mem.req = 1'b1;
					s_d.mem.we = 1'b1;
					s_d.mem.addr = s_q.cur_tgt;
					s_d.mem.wdata = buf_out_data;
				end else if (s_q.mem.req && mem_ack) begin
					s_d.mem.req = 1'b0;
					s_d.mem.we = 1'b0;
					s_d.cur_tgt = step(s_q.cur_tgt, s_q.target_in_tx_ring, tx_ring_start_page,
						tx_ring_end_page);
					s_d.remain = s_q.remain - 16'h0001;
					s_d.chunk = s_q.chunk + 8'h01;
					if (s_q.remain == 16'h0001) begin
						s_d.go = 1'b0;
						s_d.source_in_rx_ring = 1'b0;
						s_d.target_in_tx_ring = 1'b0;
						s_d.done_flag = 1'b1;
						s_d.state = scd_pkg::ST_IDLE;
					end else if (s_q.chunk == 8'(scd_pkg::CHUNK_BYTES - 1)) begin
						s_d.chunk = 8'h00;
						s_d.gap = 16'(GAP_CYC);
						s_d.state = scd_pkg::ST_GAP;
					end else begin
						s_d.state = scd_pkg::ST_RD;
					end
				end
			end
			scd_pkg::ST_GAP: begin
				if (s_q.gap == 16'h0000)
					s_d.state = scd_pkg::ST_RD;
				else
					s_d.gap = s_q.gap - 16'h0001;
			end
			default: begin
			end
		endcase
		// Stop only with no access in flight, so the arbiter never sees a dropped request
		if (s_q.fs && !s_q.mem.req) begin
			s_d.go = 1'b0;
			s_d.fs = 1'b0;
			s_d.source_in_rx_ring = 1'b0;
			s_d.target_in_tx_ring = 1'b0;
			s_d.state = scd_pkg::ST_IDLE;
		end
		// Status read clears flags first so a same-cycle event still lands
		if (sfr_rd && (sfr_addr == scd_pkg::SFR_STATUS)) begin
			s_d.rdata = {6'h00, s_q.to_flag, s_q.done_flag};
			s_d.to_flag = 1'b0;
			s_d.done_flag = 1'b0;
		end else if (sfr_rd && (sfr_addr == scd_pkg::SFR_DATA)) begin
			s_d.rdata = rd_view[s_q.rptr*8 +: 8];
			if (s_q.rptr != 2'd3)
				s_d.rptr = s_q.rptr + 2'd1;
			if (s_q.idx == scd_pkg::IDX_CSR)
				s_d.err = 1'b0;
		end else if (sfr_rd) begin
			s_d.rdata = 8'h00;
		end
		if (tmr_hit)
			s_d.to_flag = 1'b1;
		if (s_q.state == scd_pkg::ST_WR && s_q.mem.req && mem_ack && s_q.remain == 16'h0001)
			s_d.done_flag = 1'b1;
		// Data writes gather bytes LSB first
		if (sfr_wr && (sfr_addr == scd_pkg::SFR_DATA)) begin
			s_d.gather[s_q.gcnt*8 +: 8] = sfr_wdata;
			if (s_q.gcnt != 2'd3)
				s_d.gcnt = s_q.gcnt + 2'd1;
		end else if (sfr_wr && (sfr_addr == scd_pkg::SFR_INDEX)) begin
			s_d.idx = sfr_wdata;
			s_d.rptr = 2'd0;
			s_d.gcnt = 2'd0;
			if (sfr_wdata == scd_pkg::IDX_ABORT) begin
				// A pending stop is not raised again, so the stop edge always clears it
				if (s_q.go && !s_q.fs)
					s_d.fs = 1'b1;
			end else if (s_q.gcnt != 2'd0 && sfr_wdata <= scd_pkg::IDX_LAST) begin
				// An index write with no gathered bytes only selects for reading
				case (sfr_wdata)
					scd_pkg::IDX_CSR: begin
						s_d.done_ie = s_q.gather[scd_pkg::CSR_IE];
						if (s_q.gather[scd_pkg::CSR_GO] && !s_q.go) begin
							s_d.go = 1'b1;
							s_d.source_in_rx_ring = s_q.gather[scd_pkg::CSR_SOURCE_IN_RX_RING];
							s_d.target_in_tx_ring = s_q.gather[scd_pkg::CSR_TARGET_IN_TX_RING];
							s_d.state = scd_pkg::ST_CHECK;
						end
						if (s_q.gather[scd_pkg::CSR_FS] && s_q.go && !s_q.fs)
							s_d.fs = 1'b1;
					end
					scd_pkg::IDX_SRC: s_d.src = s_q.gather[23:0];
					scd_pkg::IDX_TGT: s_d.tgt = s_q.gather[23:0];
					scd_pkg::IDX_CNT: s_d.cnt = s_q.gather[15:0];
					scd_pkg::IDX_TMR: s_d.tmr = s_q.gather[15:0] & scd_pkg::TMR_WMASK;
					default: begin
					end
				endcase
			end
		end
		// Shared line follows the enabled flags as they will stand next cycle
		s_d.irq = (s_d.done_flag && s_d.done_ie)
			|| (s_d.to_flag && s_d.tmr[scd_pkg::TMR_IE]);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.state <= scd_pkg::ST_IDLE;
			s_q.tmr <= scd_pkg::TMR_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence seq_rd_done;
		s_q.state == scd_pkg::ST_RD && s_q.mem.req && mem_ack && !s_q.fs;
	endsequence
	sequence seq_wr_issue;
		s_q.state == scd_pkg::ST_WR ##1 (mem_req && mem_we);
	endsequence

	// A stop landing on the read's ack edge legally skips the write
	a_rd_then_wr: assert property (seq_rd_done ##1 !s_q.fs |-> seq_wr_issue)
		else $error("read not followed by write");
	a_zero_count_err: assert property (s_q.state == scd_pkg::ST_CHECK && s_q.cnt == 16'h0000
		|=> s_q.err && s_q.go && s_q.state == scd_pkg::ST_ERR)
		else $error("zero count not flagged");
	a_stop_clears: assert property (s_q.fs && !mem_req
		|=> !s_q.go && !s_q.fs && !s_q.source_in_rx_ring && !s_q.target_in_tx_ring)
		else $error("force stop left bits set");
	a_go_self_clear: assert property ($fell(s_q.go) |-> s_q.done_flag || $past(s_q.fs))
		else $error("run bit cleared without cause");
	a_chunk_gap: assert property ($rose(s_q.state == scd_pkg::ST_GAP)
		|-> $past(s_q.chunk) == 8'd127)
		else $error("chunk boundary wrong");
	a_linear_src: assert property (seq_rd_done ##0 !s_q.source_in_rx_ring
		|=> s_q.cur_src == $past(s_q.cur_src) + 24'h00_0001)
		else $error("source not stepped by one");
	a_src_commit: assert property (sfr_wr && sfr_addr == scd_pkg::SFR_INDEX
		&& sfr_wdata == scd_pkg::IDX_SRC && s_q.gcnt == 2'd3
		|=> s_q.src == $past(s_q.gather[23:0]))
		else $error("source commit wrong");
	a_irq_level: assert property (s_q.done_flag && s_q.done_ie |-> shared_irq_line)
		else $error("interrupt dropped while flag set");
	a_status_clear: assert property (sfr_rd && sfr_addr == scd_pkg::SFR_STATUS && !tmr_hit
		|=> !s_q.to_flag && sfr_rdata[scd_pkg::ST_TO] == $past(s_q.to_flag))
		else $error("timeout flag not read-cleared");
endmodule

// *** dv/scd_mem_model.sv ***
// Purpose: Memory arbiter model answering the copy engine's byte requests
// Assumes: One request at a time, held until ack
// Notes: Ack delay is random 0..3 cycles, so prompt and slow answers both occur
module scd_mem_model (
	input wire logic clk,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [int];
	int dly = 0;
	initial begin
		mem_ack = 1'b0;
		mem_rdata = 8'h00;
	end
	// One ack pulse per held request; read data toggles outside the ack cycle
	always @(posedge clk) begin
		mem_rdata <= ~mem_rdata;
		if (mem_ack) begin
			mem_ack <= 1'b0;
		end else if (mem_req && dly > 0) begin
			dly <= dly - 1;
		end else if (mem_req) begin
			mem_ack <= 1'b1;
			dly <= $urandom_range(3, 0);
			if (mem_we) begin
				mem[int'(mem_addr)] = mem_wdata;
			end else begin
				mem_rdata <= mem[int'(mem_addr)];
			end
		end
	end
endmodule

// *** dv/scd_top_tb.sv ***
// Purpose: Self-checking bench for the copy engine and millisecond timer
// Assumes: Short millisecond and chunk-gap counts set through parameters
// Notes: Expected read bytes are queued by the driver and popped by a monitor
module scd_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 20;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic [15:0] rxs = 16'h0030;
	logic [15:0] rxe = 16'h0031;
	logic [15:0] txs = 16'h0040;
	logic [15:0] txe = 16'h0041;
	logic mem_req, mem_we, mem_ack, irq;
	logic [23:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata;
	logic [7:0] exp_q [$];
	logic pend = 1'b0;
	int n_mismatch = 0;
	int check_count = 0;

	// Free-running clock, 8 ns period
	always #4 clk = ~clk;

	scd_top #(.CYC_PER_MS(MS), .GAP_CYC(2)) u_dut (.clk(clk), .reset_n(reset_n),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata), .rx_ring_start_page(rxs), .rx_ring_end_page(rxe),
		.tx_ring_start_page(txs), .tx_ring_end_page(txe), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata), .shared_irq_line(irq));
	scd_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Read data is registered, so it is compared one edge after the strobe
	always @(posedge clk) begin
		if (pend) begin
			check("sfr_rdata", sfr_rdata, exp_q.pop_front());
		end
		pend <= sfr_rd;
	end

	// One strobe cycle, then an idle edge so no signal is driven twice at once
	task automatic sfr(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= wr;
		sfr_rd <= ~wr;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
	endtask

	task automatic reg_w(input logic [7:0] idx, input logic [23:0] v, input int n);
		for (int i = 0; i < n; i++) begin
			sfr(1'b1, scd_pkg::SFR_DATA, v[8*i+:8]);
		end
		sfr(1'b1, scd_pkg::SFR_INDEX, idx);
	endtask

	task automatic reg_r(input logic [7:0] idx, input logic [23:0] e, input int n);
		sfr(1'b1, scd_pkg::SFR_INDEX, idx);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(e[8*i+:8]);
			sfr(1'b0, scd_pkg::SFR_DATA, 8'h00);
		end
	endtask

	task automatic rd_status(input logic [7:0] e);
		exp_q.push_back(e);
		sfr(1'b0, scd_pkg::SFR_STATUS, 8'h00);
	endtask

	task automatic wait_irq(input int lim);
		for (int k = 0; k < lim && irq !== 1'b1; k++) begin
			@(posedge clk);
		end
	endtask

	// Source bytes are laid along the ring when the receive flag is set
	task automatic copy(input logic [23:0] s, input logic [23:0] t, input int n,
		input logic [7:0] cs);
		logic [23:0] a;
		logic [7:0] v [$];
		a = s;
		for (int i = 0; i < n; i++) begin
			v.push_back(8'($urandom));
			u_mem.mem[int'(a)] = v[i];
			a = (cs[4] && a[7:0] == 8'hff && a[23:8] == rxe) ? {rxs, 8'h00} : a + 24'h1;
		end
		reg_w(scd_pkg::IDX_SRC, s, 3);
		reg_w(scd_pkg::IDX_TGT, t, 3);
		reg_w(scd_pkg::IDX_CNT, 24'(n), 2);
		reg_w(scd_pkg::IDX_CSR, 24'(cs), 1);
		wait_irq(16 * n + 200);
		check("copy_irq", irq, 1'b1);
		rd_status(8'h01);
		rd_status(8'h00);
		repeat (3) @(posedge clk);
		check("irq_drop", irq, 1'b0);
		reg_r(scd_pkg::IDX_CSR, 24'h80, 1);
		a = t;
		for (int i = 0; i < n; i++) begin
			check("tgt_byte", u_mem.mem[int'(a)], v[i]);
			a = (cs[5] && a[7:0] == 8'hff && a[23:8] == txe) ? {txs, 8'h00} : a + 24'h1;
		end
		$display("test copy %0d bytes done", n);
	endtask

	// A refused copy keeps run set with the error bit until stopped
	task automatic err_case(input logic [23:0] s, input logic [23:0] t, input logic [15:0] n,
		input logic [7:0] cs, input logic ab);
		reg_w(scd_pkg::IDX_SRC, s, 3);
		reg_w(scd_pkg::IDX_TGT, t, 3);
		reg_w(scd_pkg::IDX_CNT, 24'(n), 2);
		reg_w(scd_pkg::IDX_CSR, 24'(cs), 1);
		repeat (10) @(posedge clk);
		check("err_no_mem", mem_req, 1'b0);
		reg_r(scd_pkg::IDX_CSR, 24'(cs | 8'h05), 1);
		if (ab) begin
			sfr(1'b1, scd_pkg::SFR_INDEX, scd_pkg::IDX_ABORT);
		end else begin
			reg_w(scd_pkg::IDX_CSR, 24'h02, 1);
		end
		repeat (10) @(posedge clk);
		reg_r(scd_pkg::IDX_CSR, 24'h00, 1);
		$display("test error case done");
	endtask

	// Watchdog sized well above the longest expected run
	initial begin
		repeat (30000) @(posedge clk);
		n_mismatch++;
		final_report();
	end

	initial begin
		logic [23:0] r;
		void'($urandom(91));
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		reg_r(scd_pkg::IDX_CSR, 24'h00, 1);
		reg_r(scd_pkg::IDX_SRC, 24'h00, 3);
		reg_r(scd_pkg::IDX_TGT, 24'h00, 3);
		reg_r(scd_pkg::IDX_CNT, 24'h00, 2);
		reg_r(scd_pkg::IDX_TMR, 24'h0001, 2);
		exp_q.push_back(8'h00);
		sfr(1'b0, scd_pkg::SFR_INDEX, 8'h00);
		r = 24'($urandom);
		reg_w(scd_pkg::IDX_TGT, r, 3);
		reg_r(scd_pkg::IDX_TGT, r, 3);
		reg_w(scd_pkg::IDX_CSR, 24'h00, 1);
		repeat (6) @(posedge clk);
		check("zero_run", mem_req, 1'b0);
		$display("test registers done");
		copy(24'h001000, 24'h002000, 130, 8'h81);
		copy(24'h0031f0, 24'h007000, 32, 8'h91);
		copy(24'h001000, 24'h0041f8, 16, 8'ha1);
		err_case(24'h001000, 24'h002000, 16'h0000, 8'h01, 1'b0);
		err_case(24'h001000, 24'h001000, 16'h0010, 8'h01, 1'b1);
		err_case(24'h001000, 24'h001008, 16'h0010, 8'h01, 1'b0);
		err_case(24'h005000, 24'h002000, 16'h0010, 8'h11, 1'b1);
		err_case(24'h001000, 24'h006000, 16'h0010, 8'h21, 1'b0);
		// Force stop in mid-copy waits out the access in flight, then drops run
		reg_w(scd_pkg::IDX_CNT, 24'h00_0040, 2);
		reg_w(scd_pkg::IDX_CSR, 24'h00_0001, 1);
		repeat (20) @(posedge clk);
		reg_w(scd_pkg::IDX_CSR, 24'h00_0002, 1);
		repeat (20) @(posedge clk);
		check("stop_idle", mem_req, 1'b0);
		reg_r(scd_pkg::IDX_CSR, 24'h00_0000, 1);
		rd_status(8'h00);
		$display("test force stop done");
		// Reset in mid-copy must bring registers and outputs back to reset values
		reg_w(scd_pkg::IDX_CSR, 24'h00_0081, 1);
		repeat (20) @(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check("rst_req", mem_req, 1'b0);
		check("rst_irq", irq, 1'b0);
		reg_r(scd_pkg::IDX_CSR, 24'h00_0000, 1);
		reg_r(scd_pkg::IDX_CNT, 24'h00_0000, 2);
		$display("test mid-run reset done");
		reg_w(scd_pkg::IDX_TMR, 24'h9003, 2);
		repeat (2 * MS + MS / 2) @(posedge clk);
		check("tmr_early", irq, 1'b0);
		wait_irq(2 * MS + 20);
		check("tmr_irq", irq, 1'b1);
		reg_w(scd_pkg::IDX_TMR, 24'h8003, 2);
		rd_status(8'h02);
		repeat (3) @(posedge clk);
		check("tmr_drop", irq, 1'b0);
		repeat (5 * MS) @(posedge clk);
		check("tmr_halt", irq, 1'b0);
		reg_w(scd_pkg::IDX_TMR, 24'h3c03, 2);
		reg_r(scd_pkg::IDX_TMR, 24'h1003, 2);
		$display("test timer done");
		final_report();
	end
endmodule
